// [design/tpf_train.sv]
// training pattern generator and write-training fifo with ahb-lite mode registers
`timescale 1ns/10ps
module tpf_train
  import tpf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // command side from the memory controller
  input wire logic lclk,
  input wire logic dram_reset_n,
  input wire logic cke,
  input wire logic cs,
  input wire logic [2:0] cmd,
  input wire logic [5:0] ca,
  // data lanes
  input wire logic [15:0] dq_in,
  input wire logic [1:0] dmi_in,
  input wire logic dqs_in,
  output logic [15:0] dq_out,
  output logic dq_oe_n,
  output logic [1:0] dmi_out,
  output logic dmi_oe_n,
  output logic dqs_out,
  output logic dqs_oe_n
);
  localparam int SYNC_W = 32;

  // link synchronisers
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic lclk_prev;
  logic dqs_prev;
  logic cke_prev;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {lclk, dram_reset_n, cke, cs, cmd, ca, dq_in, dmi_in, dqs_in};
      sync2 <= sync1;
    end
  end

  logic l_clk;
  logic l_rst_n;
  logic l_cke;
  logic l_cs;
  logic [2:0] l_cmd;
  logic [5:0] l_ca;
  logic [15:0] l_dq;
  logic [1:0] l_dmi;
  logic l_dqs;

  assign {l_clk, l_rst_n, l_cke, l_cs, l_cmd, l_ca, l_dq, l_dmi, l_dqs} = sync2;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      lclk_prev <= 1'b0;
      dqs_prev <= 1'b0;
      cke_prev <= 1'b0;
    end
    else
    begin
      lclk_prev <= l_clk;
      dqs_prev <= l_dqs;
      cke_prev <= l_cke;
    end
  end

  logic lclk_rise;
  logic dqs_edge;
  logic ptr_clear;
  logic cmd_take;

  assign lclk_rise = l_clk & ~lclk_prev;
  assign dqs_edge = l_dqs ^ dqs_prev;
  // power-down and self-refresh power-down both enter through cke falling
  assign ptr_clear = ~l_rst_n | (cke_prev & ~l_cke);
  assign cmd_take = lclk_rise & l_cs & l_cke & l_rst_n;

  // mode registers
  logic [7:0] pat_first;
  logic [7:0] pat_second;
  logic [7:0] inv_lane0;
  logic [7:0] inv_lane1;
  logic [7:0] inversion_config_reg;
  logic [7:0] mask_config_reg;
  logic [3:0] read_lat;
  logic [3:0] write_lat;
  logic rsvd_seen;

  // ahb-lite slave: writes complete with no wait, reads with one
  logic ap_write;
  logic ap_read;
  logic [7:0] ap_addr;
  logic rd_ready;
  logic ap_valid;
  logic wr_do;

  assign ap_valid = hsel & htrans[1] & hready;
  assign wr_do = ap_write & hready;
  assign hreadyout = ~(ap_read & ~rd_ready);
  assign hresp = 1'b0;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ap_write <= 1'b0;
      ap_read <= 1'b0;
      ap_addr <= '0;
    end
    else if (hready)
    begin
      ap_write <= ap_valid & hwrite;
      ap_read <= ap_valid & ~hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pat_first <= RST_PAT_FIRST;
      pat_second <= RST_PAT_SECOND;
      inv_lane0 <= RST_INV_MASK;
      inv_lane1 <= RST_INV_MASK;
      inversion_config_reg <= '0;
      mask_config_reg <= '0;
      read_lat <= RST_READ_LAT;
      write_lat <= RST_WRITE_LAT;
    end
    else if (wr_do)
    begin
      unique case (ap_addr)
        OFF_PAT_FIRST: pat_first <= hwdata[7:0];
        OFF_PAT_SECOND: pat_second <= hwdata[7:0];
        OFF_INV_LANE0: inv_lane0 <= hwdata[7:0];
        OFF_INV_LANE1: inv_lane1 <= hwdata[7:0];
        OFF_INV_CFG: inversion_config_reg <= hwdata[7:0];
        OFF_MASK_CFG: mask_config_reg <= hwdata[7:0];
        OFF_LATENCY:
        begin
          read_lat <= hwdata[LAT_RD_LSB +: 4];
          write_lat <= hwdata[LAT_WR_LSB +: 4];
        end
        default:
        begin
        end
      endcase
    end
  end

  // pointers, state machine and burst counters
  tpf_state_type state;
  tpf_op_type op;
  logic [2:0] wptr;
  logic [2:0] rptr;
  logic [3:0] lat_cnt;
  logic [3:0] beat;
  logic mpc_rsvd;
  logic wr_last;
  logic rd_last;
  logic rd_active;

  assign mpc_rsvd = cmd_take && l_cmd == CMD_MPC && l_ca[MPC_EN_BIT] &&
    l_ca[4:0] != MPC_RD_FIFO && l_ca[4:0] != MPC_RD_CAL && l_ca[4:0] != MPC_WR_FIFO;
  assign wr_last = state == ST_BURST && op == OP_WR_FIFO && dqs_edge && beat == BEAT_LAST;
  assign rd_last = state == ST_BURST && op != OP_WR_FIFO && lclk_rise && beat == BEAT_LAST;
  assign rd_active = state == ST_BURST && op != OP_WR_FIFO;

  function automatic logic [2:0] ptr_step(input logic [2:0] p);
    ptr_step = (p == PTR_LAST) ? 3'h0 : p + 3'h1;
  endfunction

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rsvd_seen <= 1'b0;
    else if (mpc_rsvd)
      rsvd_seen <= 1'b1;
    else if (wr_do && ap_addr == OFF_STATUS && hwdata[ST_RSVD_BIT])
      rsvd_seen <= 1'b0;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      op <= OP_NONE;
      lat_cnt <= '0;
      beat <= '0;
    end
    else if (ptr_clear)
    begin
      state <= ST_IDLE;
      op <= OP_NONE;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          // operand bit 5 low leaves the machine idle: no-operation
          if (cmd_take && l_cmd == CMD_MPC && l_ca[MPC_EN_BIT])
          begin
            unique case (l_ca[4:0])
              MPC_WR_FIFO:
              begin
                op <= OP_WR_FIFO;
                state <= ST_ARMED;
              end
              MPC_RD_FIFO:
              begin
                op <= OP_RD_FIFO;
                state <= ST_ARMED;
              end
              MPC_RD_CAL:
              begin
                op <= OP_RD_CAL;
                state <= ST_ARMED;
              end
              default: op <= OP_NONE;
            endcase
          end
        ST_ARMED:
          // the cas must come on the very next link edge, else the command is dropped
          if (lclk_rise)
            state <= (cmd_take && l_cmd == CMD_CAS2) ? ST_CAS : ST_IDLE;
        ST_CAS:
          if (lclk_rise)
          begin
            lat_cnt <= (op == OP_WR_FIFO) ? write_lat : read_lat;
            beat <= '0;
            if (((op == OP_WR_FIFO) ? write_lat : read_lat) == 4'h0)
              state <= ST_BURST;
            else
              state <= ST_LATENCY;
          end
        ST_LATENCY:
          if (lclk_rise)
          begin
            if (lat_cnt == 4'h1)
              state <= ST_BURST;
            lat_cnt <= lat_cnt - 4'h1;
          end
        ST_BURST:
          if (wr_last || rd_last)
          begin
            state <= ST_IDLE;
            op <= OP_NONE;
          end
          else if ((op == OP_WR_FIFO) ? dqs_edge : lclk_rise)
            beat <= beat + 4'h1;
        default:
        begin
          state <= ST_IDLE;
          op <= OP_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else if (ptr_clear)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else if (cmd_take && l_cmd == CMD_READ)
    begin
      wptr <= ptr_step(wptr);
      rptr <= ptr_step(rptr);
    end
    else
    begin
      if (wr_last)
        wptr <= ptr_step(wptr);
      if (rd_last && op == OP_RD_FIFO)
        rptr <= ptr_step(rptr);
    end
  end

  // fifo storage: reset to zero so unwritten entries read at defined levels
  logic [LANE_PINS-1:0] fifo_mem [FIFO_DEPTH][BURST_LEN];

  genvar e;
  generate
    for (e = 0; e < FIFO_DEPTH; e++)
    begin : g_entry
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
        begin
          for (int b = 0; b < BURST_LEN; b++)
            fifo_mem[e][b] <= '0;
        end
        else if (state == ST_BURST && op == OP_WR_FIFO && dqs_edge && wptr == e)
          fifo_mem[e][beat] <= {l_dmi, l_dq};
      end
    end
  endgenerate

  // read burst data
  logic [15:0] cal_word;
  logic cal_bit;
  logic dmi_drive;

  assign cal_word = {pat_second, pat_first};
  assign cal_bit = cal_word[beat];
  assign dmi_drive = ~(mask_config_reg[DM_DIS_BIT] & ~inversion_config_reg[WDBI_BIT] &
    ~inversion_config_reg[RDBI_BIT]);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      dq_out <= '0;
      dmi_out <= '0;
      dq_oe_n <= 1'b1;
      dmi_oe_n <= 1'b1;
      dqs_out <= 1'b0;
      dqs_oe_n <= 1'b1;
    end
    else if (rd_active)
    begin
      if (op == OP_RD_CAL)
      begin
        // no bus inversion here whatever the read inversion enable says
        dq_out <= {16{cal_bit}} ^ {inv_lane1, inv_lane0};
        dmi_out <= {DMI_PINS{cal_bit}};
      end
      else
      begin
        dq_out <= fifo_mem[rptr][beat][DQ_PINS-1:0];
        dmi_out <= fifo_mem[rptr][beat][LANE_PINS-1:DQ_PINS];
      end
      dq_oe_n <= 1'b0;
      dmi_oe_n <= ~dmi_drive;
      dqs_out <= ~beat[0];
      dqs_oe_n <= 1'b0;
    end
    else
    begin
      dq_out <= '0;
      dmi_out <= '0;
      dq_oe_n <= 1'b1;
      dmi_oe_n <= 1'b1;
      dqs_out <= 1'b0;
      dqs_oe_n <= 1'b1;
    end
  end

  // register read path
  logic [31:0] rd_value;

  always_comb
  begin
    rd_value = '0;
    unique case (ap_addr)
      OFF_PAT_FIRST: rd_value[7:0] = pat_first;
      OFF_PAT_SECOND: rd_value[7:0] = pat_second;
      OFF_INV_LANE0: rd_value[7:0] = inv_lane0;
      OFF_INV_LANE1: rd_value[7:0] = inv_lane1;
      OFF_INV_CFG: rd_value[7:0] = inversion_config_reg;
      OFF_MASK_CFG: rd_value[7:0] = mask_config_reg;
      OFF_LATENCY:
      begin
        rd_value[LAT_RD_LSB +: 4] = read_lat;
        rd_value[LAT_WR_LSB +: 4] = write_lat;
      end
      OFF_STATUS:
      begin
        rd_value[ST_WPTR_LSB +: 3] = wptr;
        rd_value[ST_RPTR_LSB +: 3] = rptr;
        rd_value[ST_BUSY_BIT] = state != ST_IDLE;
        rd_value[ST_RSVD_BIT] = rsvd_seen;
      end
      default: rd_value = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rd_ready <= 1'b0;
      hrdata <= '0;
    end
    else
    begin
      rd_ready <= ap_read & ~rd_ready;
      if (ap_read && !rd_ready)
        hrdata <= rd_value;
    end
  end
endmodule

// [design/tpf_pkg.sv]
// constants, types and register map of the training pattern and fifo block
package tpf_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_PAT_FIRST = 8'h00;
  localparam logic [7:0] OFF_PAT_SECOND = 8'h04;
  localparam logic [7:0] OFF_INV_LANE0 = 8'h08;
  localparam logic [7:0] OFF_INV_LANE1 = 8'h0C;
  localparam logic [7:0] OFF_INV_CFG = 8'h10;
  localparam logic [7:0] OFF_MASK_CFG = 8'h14;
  localparam logic [7:0] OFF_LATENCY = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  // reset values
  localparam logic [7:0] RST_PAT_FIRST = 8'h5A;
  localparam logic [7:0] RST_PAT_SECOND = 8'h3C;
  localparam logic [7:0] RST_INV_MASK = 8'h55;
  localparam logic [3:0] RST_READ_LAT = 4'h6;
  localparam logic [3:0] RST_WRITE_LAT = 4'h4;
  // field positions
  localparam int WDBI_BIT = 7;
  localparam int RDBI_BIT = 6;
  localparam int DM_DIS_BIT = 5;
  localparam int LAT_RD_LSB = 0;
  localparam int LAT_WR_LSB = 8;
  localparam int ST_WPTR_LSB = 0;
  localparam int ST_RPTR_LSB = 4;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_RSVD_BIT = 9;
  localparam int MPC_EN_BIT = 5;
  // training function codes on operand bits 4..0
  localparam logic [4:0] MPC_RD_FIFO = 5'h01;
  localparam logic [4:0] MPC_RD_CAL = 5'h03;
  localparam logic [4:0] MPC_WR_FIFO = 5'h07;
  // sizes
  localparam int FIFO_DEPTH = 5;
  localparam int BURST_LEN = 16;
  localparam int DQ_PINS = 16;
  localparam int DMI_PINS = 2;
  localparam int LANE_PINS = DQ_PINS + DMI_PINS;
  localparam logic [2:0] PTR_LAST = 3'h4;
  localparam logic [3:0] BEAT_LAST = 4'hF;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_MPC = 3'b001,
    CMD_CAS2 = 3'b010,
    CMD_READ = 3'b011,
    CMD_WRITE = 3'b100
  } tpf_cmd_type;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_WR_FIFO = 2'b01,
    OP_RD_FIFO = 2'b10,
    OP_RD_CAL = 2'b11
  } tpf_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_CAS = 3'b010,
    ST_LATENCY = 3'b011,
    ST_BURST = 3'b100
  } tpf_state_type;
endpackage

// [dv/tpf_train_props.sv]
// port assertions for the training pattern and fifo block
`timescale 1ns/10ps
module tpf_train_props
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // ahb-lite
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // link side
  input wire logic lclk,
  input wire logic dram_reset_n,
  input wire logic cke,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic dmi_oe_n,
  input wire logic dqs_out
);
  int rises;
  int len;
  int age;
  // age saturates so a stopped link cannot wrap it
  always_ff @(posedge mclk or posedge reset)
    if (reset)
    begin
      rises <= 0;
      len <= 0;
      age <= 0;
    end
    else
    begin
      rises <= dq_oe_n ? 0 : rises + int'($rose(dqs_out));
      len <= dq_oe_n ? 0 : len + 1;
      age <= $rose(lclk) ? 0 : (age > 30 ? age : age + 1);
    end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_rd_req;
    hsel && htrans[1] && !hwrite && hready;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_pd_entry;
    $fell(cke) ##1 !cke [*5];
  endsequence
  property p_rd_wait;
    s_rd_req |=> s_one_wait;
  endproperty
  property p_wr_nowait;
    hsel && htrans[1] && hwrite && hready |=> hreadyout;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_beats;
    $rose(dq_oe_n) && cke && dram_reset_n |-> rises == 8;
  endproperty
  property p_len;
    $rose(dq_oe_n) && cke && dram_reset_n |-> len inside {[127:130]};
  endproperty
  property p_dmi_in_burst;
    !dmi_oe_n |-> !dq_oe_n;
  endproperty
  property p_beat_edge;
    $changed(dq_out) && !dq_oe_n |-> age <= 6;
  endproperty
  property p_reset_abort;
    !dram_reset_n [*6] |=> dq_oe_n;
  endproperty
  property p_pd_abort;
    s_pd_entry |=> dq_oe_n;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read lacks one wait state");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_beats: assert property (p_beats) else $error("strobe count wrong");
  a_len: assert property (p_len) else $error("burst length wrong");
  a_dmi_in_burst: assert property (p_dmi_in_burst) else $error("mask pin driven alone");
  a_beat_edge: assert property (p_beat_edge) else $error("beat off link edge");
  a_reset_abort: assert property (p_reset_abort) else $error("burst survives reset");
  a_pd_abort: assert property (p_pd_abort) else $error("burst survives power-down");
endmodule
bind tpf_train tpf_train_props i_tpf_train_props (.mclk(mclk), .reset(reset), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .lclk(lclk), .dram_reset_n(dram_reset_n), .cke(cke), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
  .dmi_oe_n(dmi_oe_n), .dqs_out(dqs_out));

// [dv/tpf_ctrl_model.sv]
// memory controller model: link clock, commands, write strobes, read capture
`timescale 1ns/10ps
module tpf_ctrl_model
  import tpf_pkg::*;
(
  // system clock
  input wire logic mclk,
  // command side
  output logic lclk,
  output logic dram_reset_n,
  output logic cke,
  output logic cs,
  output logic [2:0] cmd,
  output logic [5:0] ca,
  // data lanes
  output logic [15:0] dq_in,
  output logic [1:0] dmi_in,
  output logic dqs_in,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic [1:0] dmi_out,
  input wire logic dmi_oe_n
);
  logic [17:0] beat [16];
  logic [17:0] wdat [16];
  logic dmi_drv;
  initial
  begin
    {dram_reset_n, cke, cs, cmd, ca, dq_in, dmi_in, dqs_in} = {2'b11, 29'h0};
    lclk = 1'b0;
    #13;
    forever #160 lclk = ~lclk;
  end
  // commands change mid-period so they are steady across the link edge
  task automatic send(input logic [2:0] c, input logic [5:0] a, input bit two);
    @(negedge lclk);
    @(posedge mclk);
    cs <= 1'b1;
    cmd <= c;
    ca <= a;
    if (two)
    begin
      @(negedge lclk);
      @(posedge mclk);
      cmd <= CMD_CAS2;
      ca <= 6'h00;
    end
    @(negedge lclk);
    @(posedge mclk);
    cs <= 1'b0;
    cmd <= CMD_NOP;
    ca <= ~ca;
  endtask
  task automatic wburst();
    repeat (12) @(posedge lclk);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      {dmi_in, dq_in} <= wdat[i];
      repeat (2) @(posedge mclk);
      dqs_in <= ~dqs_in;
      repeat (2) @(posedge mclk);
    end
    {dmi_in, dq_in} <= ~wdat[15];
    repeat (6) @(posedge mclk);
  endtask
  // samples mid-beat; ok stays low if nothing is driven
  task automatic rburst(output bit ok);
    ok = 1'b0;
    for (int t = 0; t < 400 && !ok; t++)
    begin
      @(negedge mclk);
      ok = (dq_oe_n === 1'b0);
    end
    repeat (4) @(negedge mclk);
    dmi_drv = (dmi_oe_n === 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      beat[i] = {dmi_out, dq_out};
      repeat (8) @(negedge mclk);
    end
  endtask
  task automatic drop(input bit rst);
    @(posedge mclk);
    if (rst)
      dram_reset_n <= 1'b0;
    else
      cke <= 1'b0;
    repeat (8) @(posedge mclk);
    dram_reset_n <= 1'b1;
    cke <= 1'b1;
    repeat (4) @(posedge lclk);
    // hand back on a system clock edge so bus requests start right after it
    @(posedge mclk);
  endtask
endmodule

// [dv/tpf_train_tb.sv]
// self-checking bench for the training pattern and fifo block
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module tpf_train_tb;
  import tpf_pkg::*;
  localparam logic [31:0] RST_TAB [8] = '{32'(RST_PAT_FIRST), 32'(RST_PAT_SECOND),
    32'(RST_INV_MASK), 32'(RST_INV_MASK), 32'h0, 32'h0, {20'h0, RST_WRITE_LAT, 4'h0,
    RST_READ_LAT}, 32'h0};
  logic mclk, reset, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic lclk, dram_reset_n, cke, cs, dqs_in, dq_oe_n, dmi_oe_n, dqs_out, dqs_oe_n;
  logic [2:0] cmd;
  logic [5:0] ca;
  logic [15:0] dq_in, dq_out;
  logic [1:0] dmi_in, dmi_out;
  int errors, compares, seed, wp, rp;
  logic [7:0] p1, p2, m0, m1, ic, mc;
  logic [31:0] tags [5];
  bit written [5];
  bit rsvd;
  tpf_train i_tpf_train (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lclk(lclk),
    .dram_reset_n(dram_reset_n), .cke(cke), .cs(cs), .cmd(cmd), .ca(ca), .dq_in(dq_in),
    .dmi_in(dmi_in), .dqs_in(dqs_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dmi_out(dmi_out),
    .dmi_oe_n(dmi_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n));
  tpf_ctrl_model i_tpf_ctrl_model (.mclk(mclk), .lclk(lclk), .dram_reset_n(dram_reset_n),
    .cke(cke), .cs(cs), .cmd(cmd), .ca(ca), .dq_in(dq_in), .dmi_in(dmi_in), .dqs_in(dqs_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dmi_out(dmi_out), .dmi_oe_n(dmi_oe_n));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ready is looked at just before the rising edge it belongs to
  task automatic wait_ready(output logic [31:0] q);
    bit r;
    r = 1'b0;
    for (int t = 0; t < 50 && !r; t++)
    begin
      @(negedge mclk);
      r = (hreadyout === 1'b1);
      q = hrdata;
      @(posedge mclk);
    end
    if (!r)
    begin
      errors++;
      complete_run();
    end
  endtask
  task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready(q);
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready(q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic stc();
    rdc(OFF_STATUS, {22'h0, rsvd, 2'b0, 3'(rp), 1'b0, 3'(wp)});
  endtask
  function automatic logic [17:0] cal_exp(int i);
    logic [15:0] w;
    w = {p2, p1};
    return {{2{w[i]}}, {16{w[i]}} ^ {m1, m0}};
  endfunction
  function automatic logic [17:0] beat_val(logic [31:0] g, int i);
    return g[17:0] ^ 18'(i * 32'h2C9B);
  endfunction
  task automatic cal();
    bit ok;
    bit drv;
    logic [17:0] e;
    i_tpf_ctrl_model.send(CMD_MPC, {1'b1, MPC_RD_CAL}, 1'b1);
    i_tpf_ctrl_model.rburst(ok);
    drv = !(mc[DM_DIS_BIT] && ic[7:6] == 2'b00);
    `CHK(ok, 1'b1)
    `CHK(i_tpf_ctrl_model.dmi_drv, drv)
    for (int i = 0; i < 16; i++)
    begin
      e = cal_exp(i);
      if (!drv)
        e[17:16] = i_tpf_ctrl_model.beat[i][17:16];
      `CHK(i_tpf_ctrl_model.beat[i], e)
    end
    repeat (12) @(posedge mclk);
  endtask
  task automatic fwrite();
    logic [31:0] g;
    g = $random(seed);
    for (int i = 0; i < 16; i++)
      i_tpf_ctrl_model.wdat[i] = beat_val(g, i);
    i_tpf_ctrl_model.send(CMD_MPC, {1'b1, MPC_WR_FIFO}, 1'b1);
    i_tpf_ctrl_model.wburst();
    tags[wp] = g;
    written[wp] = 1'b1;
    wp = (wp + 1) % FIFO_DEPTH;
  endtask
  task automatic fread();
    bit ok;
    logic [17:0] v;
    i_tpf_ctrl_model.send(CMD_MPC, {1'b1, MPC_RD_FIFO}, 1'b1);
    i_tpf_ctrl_model.rburst(ok);
    `CHK(ok, 1'b1)
    for (int i = 0; i < 16; i++)
    begin
      v = i_tpf_ctrl_model.beat[i];
      if (written[rp])
        `CHK(v, beat_val(tags[rp], i))
      else
        `CHK((^v) !== 1'bx, 1'b1)
    end
    rp = (rp + 1) % FIFO_DEPTH;
    repeat (12) @(posedge mclk);
  endtask
  task automatic clear_ptrs();
    wp = 0;
    rp = 0;
    written = '{default: 1'b0};
  endtask
  // cut a live calibration burst by power-down or device reset
  task automatic cut(input bit rst);
    bit ok;
    ok = 1'b0;
    i_tpf_ctrl_model.send(CMD_MPC, {1'b1, MPC_RD_CAL}, 1'b1);
    for (int t = 0; t < 400 && !ok; t++)
    begin
      @(negedge mclk);
      ok = (dq_oe_n === 1'b0);
    end
    `CHK(dqs_oe_n, 1'b0)
    i_tpf_ctrl_model.drop(rst);
    `CHK(dq_oe_n, 1'b1)
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk);
    errors++;
    complete_run();
  end
  initial
  begin
    bit ok;
    seed = 10;
    {errors, compares, wp, rp, rsvd} = '0;
    {reset, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
    clear_ptrs();
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (int r = 0; r < 8; r++)
      rdc(8'(r * 4), RST_TAB[r]);
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h20, 32'h0);
    $display("test registers done");
    {p1, p2, m0, m1, ic, mc} = {RST_PAT_FIRST, RST_PAT_SECOND, {2{RST_INV_MASK}}, 16'h0};
    for (int k = 0; k < 9; k++)
    begin
      if (k > 0)
      begin
        {p1, p2, m0, m1} = k == 1 ? 32'h1C59_5555 : $random(seed);
        ic = {k[1:0], 6'(k * 7)};
        mc = {2'b0, k[2], 5'h0};
        wr(OFF_PAT_FIRST, {24'h0, p1});
        wr(OFF_PAT_SECOND, {24'h0, p2});
        wr(OFF_INV_LANE0, {24'h0, m0});
        wr(OFF_INV_LANE1, {24'h0, m1});
        wr(OFF_INV_CFG, {24'h0, ic});
        wr(OFF_MASK_CFG, {24'h0, mc});
      end
      cal();
    end
    $display("test calibration done");
    wr(OFF_INV_CFG, 32'h0);
    wr(OFF_MASK_CFG, 32'h0);
    repeat (3) fwrite();
    stc();
    repeat (8) fread();
    stc();
    repeat (4) fwrite();
    repeat (4) fread();
    i_tpf_ctrl_model.send(CMD_READ, 6'h0, 1'b0);
    wp = wp + 1;
    rp = rp + 1;
    repeat (12) @(posedge mclk);
    stc();
    $display("test fifo done");
    cut(1'b0);
    clear_ptrs();
    stc();
    i_tpf_ctrl_model.send(CMD_MPC, {1'b0, MPC_RD_CAL}, 1'b0);
    i_tpf_ctrl_model.rburst(ok);
    `CHK(ok, 1'b0)
    i_tpf_ctrl_model.send(CMD_MPC, {1'b1, 5'h02}, 1'b1);
    rsvd = 1'b1;
    repeat (12) @(posedge mclk);
    stc();
    wr(OFF_STATUS, 32'h200);
    rsvd = 1'b0;
    stc();
    fwrite();
    i_tpf_ctrl_model.send(CMD_MPC, {1'b1, MPC_WR_FIFO}, 1'b1);
    i_tpf_ctrl_model.drop(1'b1);
    cut(1'b1);
    clear_ptrs();
    stc();
    fwrite();
    fread();
    $display("test pointer reset done");
    complete_run();
  end
endmodule
